// [rtl/pack_cfg_pkg.sv]
// package: pack configuration word layout, reset values and storage location
package pack_cfg_pkg;

	// storage location of the word in configuration storage
	localparam logic [7:0]  SUBCLASS_ID     = 8'h40;
	localparam logic [7:0]  WORD_OFFSET     = 8'h00;

	// bit positions within the 16-bit word
	localparam int RESERVE_NOLOAD_BIT  = 15;
	localparam int CAL_PERMIT_BIT      = 14;
	localparam int DIVIDER_SEL_BIT     = 11;
	localparam int WAKE_HI_BIT         = 10;
	localparam int WAKE_LO_BIT         = 8;
	localparam int TENFOLD_BIT         = 7;
	localparam int RES_STEP_BIT        = 6;
	localparam int SLEEP_PERMIT_BIT    = 5;
	localparam int CAP_UPDATE_BIT      = 4;
	localparam int TEMP_SRC_BIT        = 0;

	// reserved positions (13,12,3,2,1) are stored but steer nothing
	localparam logic [15:0] RESERVED_MASK   = 16'h300E;

	// reset: wake 001, resistance step 1, sleep 1, temperature source 1
	localparam logic [15:0] WORD_RESET      = 16'h0161;

	typedef struct packed {
		logic       reserve_noload_rate_en;
		logic       calibration_permit;
		logic       divider_select;
		logic [2:0] current_wake_level;
		logic       tenfold_scale_flag;
		logic       resistance_step_en;
		logic       sleep_permit;
		logic       capacity_update_on_term;
		logic       temperature_source_sel;
	} cfg_fields_type;

	typedef struct packed {
		logic       sleep_ok;
		logic       cal_request;
		logic       term_valid;
	} gauge_cond_type;

	typedef struct packed {
		logic       sleep_enter;
		logic       cal_enter;
		logic       load_remaining;
	} gauge_ctrl_type;

endpackage

// [rtl/pack_config_register.sv]
// pack configuration word: storage, field decode and control gating
//
// Behaviour
// [RULE1] The word lives in configuration storage at subclass 64, offset 0.
// [RULE2] Software reaches the word only through the generic storage access.
// [RULE3] Divider select picks the external divider at 1, internal at 0.
// [RULE4] Software keeps the internal divider only for a single cell.
// [RULE5] The tenfold flag changes no computation, it is only carried.
// [RULE6] Software scales current, capacity and energy by ten when flagged.
// [RULE7] Software calibrates current gain to a tenth for tenfold scaling.
// [RULE8] Temperature source picks the external thermistor when set.
// [RULE9] Software keeps reserved low-byte bits untouched on rewrite.
// [RULE10] Valid termination with capacity update set loads remaining cap.
// [RULE11] The word's high and low bytes carry the fields in fixed order.
// [RULE12] Sleep needs sleep permit, calibration needs calibration permit.
`timescale 1ns/1ps

module pack_config_register (
	input  wire logic                        clock,
	input  wire logic                        rst,
	input  wire logic                        clock_en,
	input  wire logic [7:0]                  access_subclass,
	input  wire logic [7:0]                  access_offset,
	input  wire logic                        access_write,
	input  wire logic [15:0]                 access_wdata,
	output logic      [15:0]                 access_rdata,
	output logic                             access_hit,
	input  wire pack_cfg_pkg::gauge_cond_type cond,
	output pack_cfg_pkg::gauge_ctrl_type     ctrl,
	output pack_cfg_pkg::cfg_fields_type     fields,
	output logic                             divider_external,
	output logic                             thermistor_external
);

	logic [15:0]                   word_q;
	logic [15:0]                   word_d;
	pack_cfg_pkg::gauge_ctrl_type  ctrl_q;
	pack_cfg_pkg::gauge_ctrl_type  ctrl_d;

	// generic storage access addresses the word by subclass and offset
	assign access_hit = (access_subclass == pack_cfg_pkg::SUBCLASS_ID) &&
		(access_offset == pack_cfg_pkg::WORD_OFFSET); // see [RULE1] [RULE2]

	always_comb begin
		word_d = word_q;
		if (access_write && access_hit) begin
			// reserved bits are stored as written; software owns them
			word_d = access_wdata; // see [RULE9]
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			word_q <= pack_cfg_pkg::WORD_RESET;
		end else if (clock_en) begin
			word_q <= word_d;
		end
	end

	// read data is the stored word, zero when the address misses
	assign access_rdata = access_hit ? word_q : 16'h0000;

	always_comb begin
		fields.reserve_noload_rate_en =
			word_q[pack_cfg_pkg::RESERVE_NOLOAD_BIT]; // see [RULE11]
		fields.calibration_permit = word_q[pack_cfg_pkg::CAL_PERMIT_BIT];
		fields.divider_select     = word_q[pack_cfg_pkg::DIVIDER_SEL_BIT];
		fields.current_wake_level =
			word_q[pack_cfg_pkg::WAKE_HI_BIT:pack_cfg_pkg::WAKE_LO_BIT];
		fields.tenfold_scale_flag = word_q[pack_cfg_pkg::TENFOLD_BIT];
		fields.resistance_step_en = word_q[pack_cfg_pkg::RES_STEP_BIT];
		fields.sleep_permit       = word_q[pack_cfg_pkg::SLEEP_PERMIT_BIT];
		fields.capacity_update_on_term =
			word_q[pack_cfg_pkg::CAP_UPDATE_BIT];
		fields.temperature_source_sel = word_q[pack_cfg_pkg::TEMP_SRC_BIT];
	end

	assign divider_external    = fields.divider_select; // see [RULE3]
	assign thermistor_external = fields.temperature_source_sel; // see [RULE8]

	// the tenfold flag feeds no control term below: it is only reported
	always_comb begin
		ctrl_d.sleep_enter = cond.sleep_ok &&
			fields.sleep_permit; // see [RULE12]
		ctrl_d.cal_enter = cond.cal_request &&
			fields.calibration_permit; // see [RULE12]
		ctrl_d.load_remaining = cond.term_valid &&
			fields.capacity_update_on_term; // see [RULE10] [RULE5]
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_q <= '0;
		end else if (clock_en) begin
			ctrl_q <= ctrl_d;
		end
	end

	assign ctrl = ctrl_q;

	// a write is one accepted cycle followed by the stored word
	sequence hit_write_seq;
		clock_en && access_write && access_hit;
	endsequence

	sequence word_is_written_seq;
		word_q == $past(access_wdata);
	endsequence

	chk_word_reset_value: assert property ( // see [RULE3]
		@(posedge clock)
		$fell(rst) |-> word_q == pack_cfg_pkg::WORD_RESET)
		else $error("word not at reset value");

	chk_reset_loads_word: assert property ( // see [RULE8]
		@(posedge clock)
		rst |=> word_q == pack_cfg_pkg::WORD_RESET)
		else $error("reset did not load word");

	chk_write_stores_word: assert property ( // see [RULE1]
		@(posedge clock) disable iff (rst)
		hit_write_seq |=> word_is_written_seq)
		else $error("hit write not stored");

	chk_reserved_stored: assert property ( // see [RULE9]
		@(posedge clock) disable iff (rst)
		hit_write_seq |=> (word_q & pack_cfg_pkg::RESERVED_MASK) ==
		($past(access_wdata) & pack_cfg_pkg::RESERVED_MASK))
		else $error("reserved bits not stored");

	chk_miss_keeps_word: assert property ( // see [RULE2]
		@(posedge clock) disable iff (rst)
		clock_en && !access_hit |=> $stable(word_q))
		else $error("miss changed word");

	chk_frozen_word: assert property ( // see [RULE1]
		@(posedge clock) disable iff (rst)
		!clock_en |=> $stable(word_q))
		else $error("word moved while frozen");

	chk_read_hit: assert property ( // see [RULE1]
		@(posedge clock) disable iff (rst)
		access_hit |-> access_rdata == word_q)
		else $error("hit read not the word");

	chk_read_miss: assert property ( // see [RULE2]
		@(posedge clock) disable iff (rst)
		!access_hit |-> access_rdata == 16'h0000)
		else $error("miss read not zero");

	chk_divider_follows: assert property ( // see [RULE3]
		@(posedge clock) disable iff (rst)
		divider_external == word_q[pack_cfg_pkg::DIVIDER_SEL_BIT])
		else $error("divider select mismatch");

	chk_thermistor_follows: assert property ( // see [RULE8]
		@(posedge clock) disable iff (rst)
		thermistor_external == word_q[pack_cfg_pkg::TEMP_SRC_BIT])
		else $error("temperature source mismatch");

	chk_capacity_load: assert property ( // see [RULE10]
		@(posedge clock) disable iff (rst)
		clock_en && cond.term_valid &&
		word_q[pack_cfg_pkg::CAP_UPDATE_BIT] |=> ctrl.load_remaining)
		else $error("remaining capacity not loaded");

	chk_capacity_field: assert property ( // see [RULE10]
		@(posedge clock) disable iff (rst)
		fields.capacity_update_on_term ==
		word_q[pack_cfg_pkg::CAP_UPDATE_BIT])
		else $error("capacity update field misplaced");

	// frozen cycles hold ctrl, so the gate is only judged after a live one
	chk_sleep_gated: assert property ( // see [RULE12]
		@(posedge clock) disable iff (rst)
		ctrl.sleep_enter && $past(clock_en) |->
		$past(word_q[pack_cfg_pkg::SLEEP_PERMIT_BIT]) &&
		$past(cond.sleep_ok))
		else $error("sleep without permit");

	chk_sleep_follows: assert property ( // see [RULE12]
		@(posedge clock) disable iff (rst)
		clock_en |=> ctrl.sleep_enter == ($past(cond.sleep_ok) &&
		$past(word_q[pack_cfg_pkg::SLEEP_PERMIT_BIT])))
		else $error("sleep request not passed");

	chk_cal_gated: assert property ( // see [RULE12]
		@(posedge clock) disable iff (rst)
		ctrl.cal_enter && $past(clock_en) |->
		$past(word_q[pack_cfg_pkg::CAL_PERMIT_BIT]) &&
		$past(cond.cal_request))
		else $error("calibration without permit");

	chk_cal_follows: assert property ( // see [RULE12]
		@(posedge clock) disable iff (rst)
		clock_en |=> ctrl.cal_enter == ($past(cond.cal_request) &&
		$past(word_q[pack_cfg_pkg::CAL_PERMIT_BIT])))
		else $error("calibration request not passed");

	chk_frozen_ctrl: assert property ( // see [RULE12]
		@(posedge clock) disable iff (rst)
		!clock_en |=> $stable(ctrl))
		else $error("control moved while frozen");

	chk_reset_ctrl: assert property ( // see [RULE12]
		@(posedge clock)
		rst |=> ctrl == '0)
		else $error("control not cleared by reset");

	chk_tenfold_inert: assert property ( // see [RULE5]
		@(posedge clock) disable iff (rst)
		clock_en && !cond.term_valid |=> !ctrl.load_remaining)
		else $error("control moved without cause");

	// the flag must not leak into any gate, set or clear
	chk_tenfold_no_effect: assert property ( // see [RULE5]
		@(posedge clock) disable iff (rst)
		clock_en |=> ctrl.load_remaining == ($past(cond.term_valid) &&
		$past(word_q[pack_cfg_pkg::CAP_UPDATE_BIT])))
		else $error("load depends on more than its cause");

	chk_wake_field: assert property ( // see [RULE11]
		@(posedge clock) disable iff (rst)
		fields.current_wake_level ==
		word_q[pack_cfg_pkg::WAKE_HI_BIT:pack_cfg_pkg::WAKE_LO_BIT])
		else $error("wake field misplaced");

	chk_reserve_field: assert property ( // see [RULE11]
		@(posedge clock) disable iff (rst)
		fields.reserve_noload_rate_en ==
		word_q[pack_cfg_pkg::RESERVE_NOLOAD_BIT])
		else $error("reserve field misplaced");

	chk_low_fields: assert property ( // see [RULE11]
		@(posedge clock) disable iff (rst)
		fields.tenfold_scale_flag == word_q[pack_cfg_pkg::TENFOLD_BIT] &&
		fields.resistance_step_en == word_q[pack_cfg_pkg::RES_STEP_BIT])
		else $error("low byte field misplaced");

endmodule

// [bench/host_model.sv]
// host software model on the storage access port
`timescale 1ns/1ps
module host_model (
	input  wire logic        clock,
	output logic      [7:0]  access_subclass,
	output logic      [7:0]  access_offset,
	output logic             access_write,
	output logic      [15:0] access_wdata
);
	initial begin
		access_subclass = 8'h40;
		access_offset = 8'h00;
		access_write = 1'b0;
		access_wdata = 16'h0000;
	end
	// reported values read ten times larger when the flag is set
	function automatic logic [15:0] report_scaled(input logic [15:0] v,
		input logic flag);
		return flag ? v * 16'h000A : v;
	endfunction
	// tenfold current comes from a gain set to a tenth of the true one
	function automatic logic [15:0] tenfold_gain(input logic [15:0] g);
		return g / 16'h000A;
	endfunction
	// only the generic storage access is used
	task automatic put(input logic [7:0] sc, input logic [15:0] d);
		@(posedge clock);
		access_subclass <= sc;
		access_write <= 1'b1;
		access_wdata <= d;
		@(posedge clock);
		access_write <= 1'b0;
		// released data shows junk, not the last value
		access_wdata <= ~d;
		#1;
	endtask
	task automatic look(input logic [7:0] sc);
		@(posedge clock);
		access_subclass <= sc;
		#1;
	endtask
endmodule

// [bench/test_pack_config_register.sv]
// testbench for the pack configuration word
`timescale 1ns/1ps
module test_pack_config_register;
	logic clock, rst, clock_en, access_write, access_hit;
	logic [7:0] access_subclass, access_offset;
	logic [15:0] access_wdata, access_rdata;
	logic divider_external, thermistor_external;
	pack_cfg_pkg::gauge_cond_type cond;
	pack_cfg_pkg::gauge_ctrl_type ctrl;
	pack_cfg_pkg::cfg_fields_type fields;
	int num_errors = 0;
	int total_checks = 0;
	pack_config_register DUT (.clock(clock), .rst(rst), .clock_en(clock_en),
		.access_subclass(access_subclass), .access_offset(access_offset),
		.access_write(access_write), .access_wdata(access_wdata),
		.access_rdata(access_rdata), .access_hit(access_hit), .cond(cond),
		.ctrl(ctrl), .fields(fields), .divider_external(divider_external),
		.thermistor_external(thermistor_external));
	host_model HOST (.clock(clock), .access_subclass(access_subclass),
		.access_offset(access_offset), .access_write(access_write),
		.access_wdata(access_wdata));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic test_store();
		check("reset word", access_rdata, 16'h0161);
		HOST.put(8'h41, 16'h1234);
		check("miss hit", {15'h0, access_hit}, 16'h0000);
		check("miss read", access_rdata, 16'h0000);
		HOST.look(8'h40);
		check("miss write", access_rdata, 16'h0161);
		check("hit", {15'h0, access_hit}, 16'h0001);
		@(posedge clock);
		clock_en <= 1'b0;
		HOST.put(8'h40, 16'hFFFF);
		@(posedge clock);
		clock_en <= 1'b1;
		#1;
		check("frozen word", access_rdata, 16'h0161);
		HOST.put(8'h40, access_rdata | 16'h300E);
		check("reserved", access_rdata, 16'h316F);
		$display("test_store done");
	endtask
	task automatic test_fields();
		// a multi-cell stack needs the external divider
		HOST.put(8'h40, 16'h8800);
		check("fields hi", {5'h0, fields}, 16'h0500);
		check("divider", {15'h0, divider_external}, 16'h0001);
		check("therm", {15'h0, thermistor_external}, 16'h0000);
		HOST.put(8'h40, 16'h0581);
		check("fields lo", {5'h0, fields}, 16'h00B1);
		check("divider 0", {15'h0, divider_external}, 16'h0000);
		check("therm 1", {15'h0, thermistor_external},
			16'h0001);
		check("scaled", HOST.report_scaled(16'h0100,
			fields.tenfold_scale_flag), 16'h0A00);
		check("gain", HOST.tenfold_gain(16'h03E8), 16'h0064);
		$display("test_fields done");
	endtask
	task automatic pulse(input logic [15:0] w, input logic [15:0] exp);
		HOST.put(8'h40, w);
		@(posedge clock);
		cond <= 3'b111;
		@(posedge clock);
		cond <= 3'b000;
		#1;
		check("ctrl", {13'h0, ctrl}, exp);
	endtask
	task automatic test_ctrl();
		pulse(16'h0010, 16'h0001);
		pulse(16'h0000, 16'h0000);
		pulse(16'h40B0, 16'h0007);
		pulse(16'h4030, 16'h0007);
		$display("test_ctrl done");
	endtask
	initial begin
		#20000;
		num_errors++;
		close_out();
	end
	initial begin
		rst = 1'b1;
		clock_en = 1'b1;
		cond = 3'b000;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		#1;
		test_store();
		test_fields();
		test_ctrl();
		close_out();
	end
endmodule
